// File: core/p5g_pkg.sv
// Constants and types shared by the port 5 GPIO block
package p5g_pkg;

    // Bus and port widths
    localparam int unsigned PINS   = 8;
    localparam int unsigned ADDR_W = 18;
    localparam int unsigned DATA_W = 32;

    // Printed register indexes; the byte address is four times the index
    localparam logic [15:0] IDX_PIN_MODE = 16'hFFCC;
    localparam logic [15:0] IDX_DATA     = 16'hFFD8;
    localparam logic [15:0] IDX_PULLUP   = 16'hFFE2;
    localparam logic [15:0] IDX_DIR      = 16'hFFE8;

    // Byte addresses on the bus
    localparam logic [ADDR_W-1:0] ADDR_PIN_MODE = {IDX_PIN_MODE, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_DATA     = {IDX_DATA, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_PULLUP   = {IDX_PULLUP, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_DIR      = {IDX_DIR, 2'b00};

    // Field position: bit n of each register belongs to pin n
    localparam int unsigned REG_LSB = 0;
    localparam int unsigned REG_MSB = 7;

    // Reset values
    localparam logic [7:0] RST_PIN_MODE = 8'h00;
    localparam logic [7:0] RST_DATA     = 8'h00;
    localparam logic [7:0] RST_PULLUP   = 8'h00;
    localparam logic [7:0] RST_DIR      = 8'h00;
    localparam logic [7:0] RST_WAKE_N   = 8'hFF;
    localparam logic [7:0] DIR_READ_VAL = 8'hFF;

    // Segment select codes that claim each half of the port
    localparam logic [3:0] SEG_HI_FIRST = 4'h2;
    localparam logic [3:0] SEG_HI_LAST  = 4'h9;
    localparam logic [3:0] SEG_LO_FIRST = 4'h1;
    localparam logic [3:0] SEG_LO_LAST  = 4'h8;

    // Operating modes of the chip, one-hot
    typedef enum logic [5:0] {
        P5G_PWR_ACTIVE    = 6'h01,
        P5G_PWR_SUBACTIVE = 6'h02,
        P5G_PWR_SLEEP     = 6'h04,
        P5G_PWR_SUBSLEEP  = 6'h08,
        P5G_PWR_STANDBY   = 6'h10,
        P5G_PWR_WATCH     = 6'h20
    } p5g_pwr_e;

    // Bus slave states, one-hot
    typedef enum logic [1:0] {
        P5G_BUS_IDLE   = 2'h1,
        P5G_BUS_ACCESS = 2'h2
    } p5g_bus_e;

endpackage : p5g_pkg

// File: core/p5g_seg_decode.sv
// Decoder from segment select code to the pins claimed as segment outputs
`timescale 1ns/1ps
module p5g_seg_decode
    import p5g_pkg::*;
(
    input  wire logic [3:0] segment_select_code,
    output wire logic [7:0] seg_claim
);

    logic hi_claim;
    logic lo_claim;

    // Each half of the port is claimed over its own code range
    assign hi_claim  = (segment_select_code >= SEG_HI_FIRST) &&
                       (segment_select_code <= SEG_HI_LAST);
    assign lo_claim  = (segment_select_code >= SEG_LO_FIRST) &&
                       (segment_select_code <= SEG_LO_LAST);
    assign seg_claim = {{4{hi_claim}}, {4{lo_claim}}};

endmodule : p5g_seg_decode

// File: core/p5g_pin_cell.sv
// Function select of one port pin: segment, wake-up or port I/O
`timescale 1ns/1ps
module p5g_pin_cell (
    input  wire logic seg_claim,
    input  wire logic wake_sel,
    input  wire logic dir,
    input  wire logic latch,
    input  wire logic seg_level,
    input  wire logic pull_sel,
    input  wire logic pin_level,
    output wire logic drive_level,
    output wire logic drive_en,
    output wire logic pull_on,
    output wire logic wake_level_n
);

    logic gpio_sel;

    // Segment beats wake-up, wake-up beats port I/O
    assign gpio_sel     = ~seg_claim & ~wake_sel;
    // Direction and latch steer the pin drive only in port I/O use
    assign drive_en     = seg_claim | (gpio_sel & dir);
    assign drive_level  = seg_claim ? seg_level : latch;
    // Pull-up only on an input with its control bit set
    assign pull_on      = ~dir & pull_sel;
    // Active-low wake-up level, idle high when not selected
    assign wake_level_n = (wake_sel & ~seg_claim) ? pin_level : 1'b1;

endmodule : p5g_pin_cell

// File: core/p5g_port5_gpio.sv
// Eight-pin port with wake-up and segment functions, APB register slave
//
// Overview of operation
// - Data read returns the latch on pins whose direction bit is one.
// - Data read returns the sampled pin level where direction bit is zero.
// - Direction bit one makes the pin an output, zero an input.
// - Direction and data steer pin drive only in port I/O use; direction gates pull-up in any use.
// - Direction register is write-only and always reads as all ones.
// - Pull-up is on only for direction zero with pull-up bit one.
// - Pull-up is off when its bit is zero or direction bit is one.
// - Outside segment use, mode bit zero is port I/O, one is wake-up input.
// - Segment use takes priority over mode bit, and over direction bit except for pull-up.
// - Pins float in reset, standby, watch; hold in sleeps; work otherwise.
// - In standby and watch an enabled pull-up still pulls the pin high.
// - The pull-up is off on every pin after reset.
// - Reset clears data, direction, pull-up and mode registers to zero.
`timescale 1ns/1ps
module p5g_port5_gpio
    import p5g_pkg::*;
(
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [p5g_pkg::ADDR_W-1:0] paddr,
    input  wire logic [p5g_pkg::DATA_W-1:0] pwdata,
    output logic                          pready,
    output logic [p5g_pkg::DATA_W-1:0]    prdata,
    output logic                          pslverr,
    input  wire p5g_pkg::p5g_pwr_e        power_mode,
    input  wire logic [3:0]               segment_select_code,
    input  wire logic [7:0]               lcd_segment_output,
    input  wire logic [7:0]               port_pin_bit_in,
    output logic [7:0]                    port_pin_bit_out,
    output logic [7:0]                    port_pin_bit_oe,
    output logic [7:0]                    pullup_enable,
    output logic [7:0]                    wakeup_input_n
);
    import p5g_pkg::*;

    // Software registers
    logic [7:0]     pin_mode_select_q;
    logic [7:0]     port_data_latch_q;
    logic [7:0]     pullup_control_q;
    logic [7:0]     direction_control_q;

    // Bus slave state and registered answers
    p5g_bus_e       bus_q;
    p5g_bus_e       bus_d;
    logic           pready_q;
    logic           pready_d;
    logic [31:0]    prdata_q;
    logic [31:0]    prdata_d;
    logic           pslverr_q;
    logic           pslverr_d;

    // Registered pin drivers
    logic [7:0]     pin_out_q;
    logic [7:0]     pin_out_d;
    logic [7:0]     pin_oe_q;
    logic [7:0]     pin_oe_d;
    logic [7:0]     pullup_q;
    logic [7:0]     pullup_d;
    logic [7:0]     wake_n_q;
    logic [7:0]     wake_n_d;

    // Decode wires
    logic           setup_phase;
    logic           access_done;
    logic           hit_mode;
    logic           hit_data;
    logic           hit_pullup;
    logic           hit_dir;
    logic           addr_hit;
    logic           wr_fire;
    logic [7:0]     data_read;
    logic [7:0]     read_byte;

    // Per-pin function results
    logic [7:0]     seg_claim;
    logic [7:0]     cell_level;
    logic [7:0]     cell_en;
    logic [7:0]     cell_pull;
    logic [7:0]     cell_wake_n;
    logic [7:0]     gpio_mask;

    // Operating mode groups
    logic           mode_run;
    logic           mode_hold;
    logic           mode_float;

    // Setup and access phase detection
    assign setup_phase = (bus_q == P5G_BUS_IDLE) && psel && !penable;
    assign access_done = (bus_q == P5G_BUS_ACCESS) && psel && penable;
    assign wr_fire     = access_done && pwrite;

    // Address decode
    assign hit_mode    = (paddr == ADDR_PIN_MODE);
    assign hit_data    = (paddr == ADDR_DATA);
    assign hit_pullup  = (paddr == ADDR_PULLUP);
    assign hit_dir     = (paddr == ADDR_DIR);
    assign addr_hit    = hit_mode | hit_data | hit_pullup | hit_dir;

    // Data read mixes latch on outputs and pin level on inputs
    assign data_read   = (port_data_latch_q & direction_control_q) |
                         (port_pin_bit_in & ~direction_control_q);

    // Read selection; direction register reads as all ones
    assign read_byte   = hit_mode   ? pin_mode_select_q :
                         hit_data   ? data_read :
                         hit_pullup ? pullup_control_q :
                         hit_dir    ? DIR_READ_VAL :
                                      8'h00;

    // Bus slave next state: one access cycle, no wait states
    assign bus_d       = setup_phase ? P5G_BUS_ACCESS :
                         access_done ? P5G_BUS_IDLE : bus_q;
    assign pready_d    = setup_phase;
    assign pslverr_d   = setup_phase && !addr_hit;
    assign prdata_d    = (setup_phase && !pwrite) ? {24'h000000, read_byte} : 32'h00000000;

    // Bus slave registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_q     <= P5G_BUS_IDLE;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end
        else
        begin
            bus_q     <= bus_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q  <= prdata_d;
        end
    end

    // Software registers, written at the completing access edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_mode_select_q   <= RST_PIN_MODE;
            port_data_latch_q   <= RST_DATA;
            pullup_control_q    <= RST_PULLUP;
            direction_control_q <= RST_DIR;
        end
        else if (wr_fire)
        begin
            if (hit_mode)
                pin_mode_select_q   <= pwdata[REG_MSB:REG_LSB];
            if (hit_data)
                port_data_latch_q   <= pwdata[REG_MSB:REG_LSB];
            if (hit_pullup)
                pullup_control_q    <= pwdata[REG_MSB:REG_LSB];
            if (hit_dir)
                direction_control_q <= pwdata[REG_MSB:REG_LSB];
        end
    end

    // Which pins the segment driver claims
    p5g_seg_decode u_seg_decode (
        .segment_select_code (segment_select_code),
        .seg_claim           (seg_claim)
    );

    // One function select cell per pin
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++)
        begin : g_pin
            p5g_pin_cell u_cell (
                .seg_claim    (seg_claim[gi]),
                .wake_sel     (pin_mode_select_q[gi]),
                .dir          (direction_control_q[gi]),
                .latch        (port_data_latch_q[gi]),
                .seg_level    (lcd_segment_output[gi]),
                .pull_sel     (pullup_control_q[gi]),
                .pin_level    (port_pin_bit_in[gi]),
                .drive_level  (cell_level[gi]),
                .drive_en     (cell_en[gi]),
                .pull_on      (cell_pull[gi]),
                .wake_level_n (cell_wake_n[gi])
            );
        end
    endgenerate

    // Pins in plain port I/O use
    assign gpio_mask  = ~seg_claim & ~pin_mode_select_q;

    // Operating mode groups
    assign mode_run   = (power_mode == P5G_PWR_ACTIVE) ||
                        (power_mode == P5G_PWR_SUBACTIVE);
    assign mode_hold  = (power_mode == P5G_PWR_SLEEP) ||
                        (power_mode == P5G_PWR_SUBSLEEP);
    assign mode_float = !mode_run && !mode_hold;

    // Pin drivers: follow in run modes, freeze in sleeps, float otherwise
    assign pin_out_d  = mode_run ? cell_level : pin_out_q;
    assign pin_oe_d   = mode_run  ? cell_en :
                        mode_hold ? pin_oe_q : 8'h00;
    // Pull-up stays in force while floating so the pin reads high
    assign pullup_d   = mode_hold ? pullup_q : cell_pull;
    assign wake_n_d   = cell_wake_n;

    // Pin driver registers; floating and pull-up off from reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out_q <= RST_DATA;
            pin_oe_q  <= 8'h00;
            pullup_q  <= RST_PULLUP;
            wake_n_q  <= RST_WAKE_N;
        end
        else
        begin
            pin_out_q <= pin_out_d;
            pin_oe_q  <= pin_oe_d;
            pullup_q  <= pullup_d;
            wake_n_q  <= wake_n_d;
        end
    end

    // Outputs straight from flip-flops
    assign pready           = pready_q;
    assign prdata           = prdata_q;
    assign pslverr          = pslverr_q;
    assign port_pin_bit_out = pin_out_q;
    assign port_pin_bit_oe  = pin_oe_q;
    assign pullup_enable    = pullup_q;
    assign wakeup_input_n   = wake_n_q;

    // Read of data: output bits show the latch
    a_rd_latch_bits: assert property (
        @(posedge pclk) disable iff (!presetn)
        (access_done && !pwrite && hit_data) |->
        ((prdata[7:0] & direction_control_q) ==
         (port_data_latch_q & direction_control_q)))
        else $error("data read did not return latch on output bits");

    // Read of data: input bits show the pin sampled at setup
    a_rd_pin_bits: assert property (
        @(posedge pclk) disable iff (!presetn)
        (access_done && !pwrite && hit_data) |->
        ((prdata[7:0] & ~direction_control_q) ==
         ($past(port_pin_bit_in) & ~direction_control_q)))
        else $error("data read did not return pin level on input bits");

    // Direction bit drives the enable of a port I/O pin
    a_dir_drives_oe: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode_run |=> ((port_pin_bit_oe & $past(gpio_mask)) ==
                      ($past(direction_control_q) & $past(gpio_mask))))
        else $error("port pin enable does not follow direction");

    // Latch drives only port I/O output pins
    a_gpio_data_out: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode_run |=> (((port_pin_bit_out ^ $past(port_data_latch_q)) &
                       $past(gpio_mask & direction_control_q)) == 8'h00))
        else $error("port output pin does not show latch");

    // Direction register reads back all ones
    a_dir_reads_ones: assert property (
        @(posedge pclk) disable iff (!presetn)
        (access_done && !pwrite && hit_dir) |->
        (prdata == {24'h000000, DIR_READ_VAL}) && pready && !pslverr)
        else $error("direction register did not read as all ones");

    // Pull-up on exactly for inputs with the bit set
    a_pull_on_input: assert property (
        @(posedge pclk) disable iff (!presetn)
        !mode_hold |=> (pullup_enable ==
                        $past(~direction_control_q & pullup_control_q)))
        else $error("pull-up enable wrong for input pin");

    // Pull-up never on for output or cleared bit
    a_pull_off_cases: assert property (
        @(posedge pclk) disable iff (!presetn)
        !mode_hold |=> ((pullup_enable & ($past(direction_control_q) |
                                          ~$past(pullup_control_q))) == 8'h00))
        else $error("pull-up on for output pin or cleared bit");

    // Wake-up pins are never driven and pass the pin level
    a_wake_select: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode_run |=> (((port_pin_bit_oe | ~wakeup_input_n ^ ~$past(port_pin_bit_in)) &
                       $past(pin_mode_select_q & ~seg_claim)) == 8'h00))
        else $error("wake-up pin driven or wrong level");

    // Segment pins drive the segment level in run modes
    a_seg_priority: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode_run |=> (((~port_pin_bit_oe |
                        (port_pin_bit_out ^ $past(lcd_segment_output))) &
                       $past(seg_claim)) == 8'h00))
        else $error("segment pin not driven by segment level");

    // Standby and watch float every pin within one cycle
    a_float_modes: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode_float |=> (port_pin_bit_oe == 8'h00))
        else $error("pin driven in standby or watch");

    // Sleep modes freeze the pin drivers
    a_sleep_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode_hold |=> ($stable(port_pin_bit_oe) && $stable(port_pin_bit_out) &&
                       $stable(pullup_enable)))
        else $error("pin state changed in sleep");

    // Pull-up held on while floating
    a_float_pullup: assert property (
        @(posedge pclk) disable iff (!presetn)
        mode_float |=> (pullup_enable ==
                        $past(~direction_control_q & pullup_control_q)))
        else $error("pull-up dropped in standby or watch");

    // Registers and pull-ups clear after reset
    a_reset_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> (pullup_enable == 8'h00) && (port_pin_bit_oe == 8'h00) &&
                           (pin_mode_select_q == 8'h00) &&
                           (port_data_latch_q == 8'h00) &&
                           (pullup_control_q == 8'h00) &&
                           (direction_control_q == 8'h00))
        else $error("state not cleared by reset");

    // Segment code ranges for each half of the port
    a_seg_codes: assert property (
        @(posedge pclk) disable iff (!presetn)
        ((segment_select_code == 4'h1) |-> (seg_claim == 8'h0F)) and
        ((segment_select_code == 4'h9) |-> (seg_claim == 8'hF0)) and
        ((segment_select_code == 4'h0) |-> (seg_claim == 8'h00)) and
        ((segment_select_code == 4'hA) |-> (seg_claim == 8'h00)))
        else $error("segment claim does not match code");

endmodule : p5g_port5_gpio

// File: tb/p5g_board.sv
// Board model: the level seen on each port 5 pin
`timescale 1ns/1ps
module p5g_board (
    input  wire logic       pclk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pull_on,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic [7:0]      pin_lvl
);
    logic tog_q = 1'b0;

    // Floating level changes every cycle so a stale value never passes
    always_ff @(posedge pclk) tog_q <= ~tog_q;

    // Port driver first, then board source, then pull-up or float
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                   | (~pin_oe & ~ext_en & (pull_on | {8{tog_q}}));
endmodule : p5g_board

// File: tb/p5g_port5_gpio_test.sv
// Register and pin tests of the port 5 block
`timescale 1ns/1ps
module p5g_port5_gpio_test;
    import p5g_pkg::*;

    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic              pready;
    logic              pslverr;
    logic              er;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic [DATA_W-1:0] rd;
    p5g_pwr_e          power_mode;
    logic [3:0]        seg_code;
    logic [7:0]        lcd_seg;
    logic [7:0]        pin_in;
    logic [7:0]        pin_out;
    logic [7:0]        pin_oe;
    logic [7:0]        pull_en;
    logic [7:0]        wake_n;
    logic [7:0]        ext_en;
    logic [7:0]        ext_val;
    logic [7:0]        claim;
    int                n_mismatch = 0;
    int                checks_done = 0;

    p5g_port5_gpio p5g_port5_gpio_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .power_mode(power_mode),
        .segment_select_code(seg_code), .lcd_segment_output(lcd_seg),
        .port_pin_bit_in(pin_in), .port_pin_bit_out(pin_out),
        .port_pin_bit_oe(pin_oe), .pullup_enable(pull_en), .wakeup_input_n(wake_n)
    );

    p5g_board p5g_board_inst (
        .pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_on(pull_en),
        .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_in)
    );

    // Compare one value and count it
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // One APB transfer; waits for pready, only the watchdog ends a hang
    task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Slave answers in the first access cycle, no wait states
        chk("apb_wait", n, 32'h1);
    endtask : apb

    // Read a register and compare
    task rdchk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask : rdchk

    // Let registered pin outputs follow
    task settle;
        repeat (3) @(posedge pclk);
        #10;
    endtask : settle

    // Verdict and end of run
    task final_report;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report

    // Clock at 100 ns
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Watchdog
    initial
    begin
        #2000000;
        n_mismatch++;
        final_report();
    end

    // Main sequence
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        power_mode = P5G_PWR_ACTIVE;
        seg_code = 4'h0;
        lcd_seg = 8'h96;
        ext_en = 8'hFF;
        ext_val = 8'h3C;
        repeat (12) @(posedge pclk);
        chk("rst_oe", pin_oe, 8'h00);
        presetn <= 1'b1;
        settle();
        chk("pull_rst", pull_en, 8'h00);
        chk("wake_rst", wake_n, 8'hFF);
        rdchk("mode_rst", ADDR_PIN_MODE, 32'h0);
        rdchk("pull_reg_rst", ADDR_PULLUP, 32'h0);
        rdchk("dir_read", ADDR_DIR, 32'hFF);
        rdchk("data_pins", ADDR_DATA, 32'h3C);
        apb(1'b1, 18'h00000, 32'hFF);
        chk("unmapped_err", er, 1'b1);
        apb(1'b1, ADDR_DIR, 32'h0F);
        apb(1'b1, ADDR_DATA, 32'hA5);
        settle();
        chk("oe_dir", pin_oe, 8'h0F);
        chk("out_latch", pin_out & 8'h0F, 8'h05);
        rdchk("data_mix", ADDR_DATA, 32'h35);
        rdchk("dir_read2", ADDR_DIR, 32'hFF);
        apb(1'b1, ADDR_PULLUP, 32'hFF);
        settle();
        chk("pull_dir", pull_en, 8'hF0);
        rdchk("pull_reg", ADDR_PULLUP, 32'hFF);
        apb(1'b1, ADDR_PIN_MODE, 32'h03);
        settle();
        chk("oe_wake", pin_oe, 8'h0C);
        chk("wake_lvl", wake_n, 8'hFC);
        rdchk("mode_reg", ADDR_PIN_MODE, 32'h03);
        for (int c = 0; c < 16; c++)
        begin
            seg_code <= c[3:0];
            settle();
            claim = {{4{c >= 2 && c <= 9}}, {4{c >= 1 && c <= 8}}};
            chk("seg_oe", pin_oe, claim | (8'h0C & ~claim));
            chk("seg_out", pin_out & claim, 8'h96 & claim);
        end
        seg_code <= 4'h0;
        power_mode <= P5G_PWR_SLEEP;
        apb(1'b1, ADDR_DATA, 32'h5A);
        apb(1'b1, ADDR_DIR, 32'h00);
        settle();
        chk("sleep_oe", pin_oe, 8'h0C);
        chk("sleep_out", pin_out & 8'h0C, 8'h04);
        chk("sleep_pull", pull_en, 8'hF0);
        power_mode <= P5G_PWR_SUBSLEEP;
        settle();
        chk("subsleep_oe", pin_oe, 8'h0C);
        power_mode <= P5G_PWR_STANDBY;
        ext_en <= 8'h00;
        settle();
        chk("stby_oe", pin_oe, 8'h00);
        chk("stby_pull", pull_en, 8'hFF);
        rdchk("stby_pins", ADDR_DATA, 32'hFF);
        power_mode <= P5G_PWR_WATCH;
        settle();
        chk("watch_oe", pin_oe, 8'h00);
        power_mode <= P5G_PWR_SUBACTIVE;
        ext_en <= 8'hFF;
        apb(1'b1, ADDR_DIR, 32'hF0);
        settle();
        chk("subact_oe", pin_oe, 8'hF0);
        chk("subact_out", pin_out & 8'hF0, 8'h50);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        #10;
        chk("rst2_oe", pin_oe, 8'h00);
        chk("rst2_pull", pull_en, 8'h00);
        presetn <= 1'b1;
        rdchk("rst2_data", ADDR_DATA, 32'h3C);
        rdchk("rst2_mode", ADDR_PIN_MODE, 32'h0);
        // Direction and latch must both be cleared, not kept from before reset
        chk("rst2_dir", pin_oe, 8'h00);
        apb(1'b1, ADDR_DIR, 32'hFF);
        rdchk("rst2_latch", ADDR_DATA, 32'h0);
        final_report();
    end
endmodule : p5g_port5_gpio_test
